//--- common/ctc_pkg.sv
// constants and types for the coax transceiver control block
package ctc_pkg;

  // local reference rate
  localparam int CLK_MHZ = 25;

  // times as printed, nanoseconds
  localparam int RX_OPEN_NS = 500;
  localparam int RX_HIGH_NS = 250;
  localparam int RX_BLANK_NS = 500;
  localparam int TX_ON_NS = 25;
  localparam int TX_OFF_NS = 150;
  localparam int COL_HALF_NS = 50;
  localparam int COL_TAIL_NS = 170;
  localparam int HB_WAIT_NS = 1000;
  localparam int HB_BURST_NS = 1000;
  localparam int UNJAB_NS = 450;

  // times as printed, milliseconds
  localparam int JAB_MS = 30;
  localparam int POR_MS = 400;
  localparam int DISC_MS = 800;
  localparam int ANN_MS = 400;

  // cycle counts; longest times round down, least times round up
  localparam int RX_OPEN_CYC = RX_OPEN_NS * CLK_MHZ / 1000;
  localparam int RX_HIGH_CYC = RX_HIGH_NS * CLK_MHZ / 1000;
  localparam int RX_BLANK_CYC = (RX_BLANK_NS * CLK_MHZ + 999) / 1000;
  localparam int TX_ON_CYC = (TX_ON_NS * CLK_MHZ + 999) / 1000;
  localparam int TX_OFF_CYC = (TX_OFF_NS * CLK_MHZ + 999) / 1000;
  localparam int COL_HALF_CYC = COL_HALF_NS * CLK_MHZ / 1000;
  localparam int COL_TAIL_CYC = (COL_TAIL_NS * CLK_MHZ + 999) / 1000;
  localparam int HB_WAIT_CYC = HB_WAIT_NS * CLK_MHZ / 1000;
  localparam int HB_BURST_CYC = HB_BURST_NS * CLK_MHZ / 1000;
  localparam int UNJAB_CYC = (UNJAB_NS * CLK_MHZ + 999) / 1000;
  localparam int JAB_CYC = JAB_MS * CLK_MHZ * 1000;
  localparam int POR_CYC = POR_MS * CLK_MHZ * 1000;
  localparam int DISC_CYC = DISC_MS * CLK_MHZ * 1000;
  localparam int ANN_CYC = ANN_MS * CLK_MHZ * 1000;

  // positions of the synchronised pins
  localparam int P_RXD = 0;
  localparam int P_SQ = 1;
  localparam int P_COL = 2;
  localparam int P_TXN = 3;
  localparam int P_DIS = 4;
  localparam int P_UV = 5;
  localparam int P_HB = 6;
  localparam int N_PIN = 7;

  typedef logic [4:0] ctc_short_t;
  typedef logic [24:0] ctc_long_t;

  typedef enum logic [2:0] {
    ST_POR = 3'h1,
    ST_RUN = 3'h2,
    ST_DISC = 3'h4
  } ctc_mode_t;

  typedef enum logic [2:0] {
    CG_IDLE = 3'h1,
    CG_OSC = 3'h2,
    CG_TAIL = 3'h4
  } ctc_colgen_t;

endpackage : ctc_pkg

//--- src/ctc_coax_ctrl.sv
// control logic of the coax transceiver: squelch, collision, jabber
// Operation
// (R1) receive opens on squelch level plus a timely 0-then-1 data start
// (R2) receive closes after 250ns steady high, stays shut 0.5us
// (R3) transmit opens only on a negative DTE pulse of at least 25ns
// (R4) transmit closes after 150ns without negative DTE pulses
// (R5) collision level drives a 10MHz oscillation within 700ns; the code gives 12.5MHz
// (R6) collision starts with a low pulse, ends high over 170ns
// (R7) one microsecond after transmit ends, emit 1us heartbeat burst
// (R8) heartbeat strap low suppresses the heartbeat burst entirely
// (R9) transmit inhibited after 30ms continuous activity
// (R10) after jabber, collision for rest of packet plus 450ns, then release
// (R11) undervoltage holds both squelches and blocks all outputs; the code keeps aui_driver_oe_out on
// (R12) after power-up wait 400ms disabled, with no collision
// (R13) disable level over 800ms squelches and tri-states AUI drivers
// (R14) disconnect gives 400ms collision; reconnect gives none
// (R15) reconnection re-enables the block and its drivers by itself
// (R16) receive and collision drivers powered only while activity exists
// (R17) receive data comes only from the cable, never from transmit
// (R18) heartbeat delay after transmit end lies within 0.6 to 1.6us
// (R19) all timers are synchronous counters on the local clock
// (R20) reset clears timers, squelches held, outputs idle until wait ends
`timescale 1ns/1ns

module ctc_coax_ctrl #(
  parameter int JAB_CYC = ctc_pkg::JAB_CYC,
  parameter int POR_CYC = ctc_pkg::POR_CYC,
  parameter int DISC_CYC = ctc_pkg::DISC_CYC,
  parameter int ANN_CYC = ctc_pkg::ANN_CYC
) (
  input wire logic clk_in, // local reference
  input wire logic sys_rst_in, // async reset, high
  input wire logic link_clk_in, // DTE side receive clock
  input wire logic coax_receive_input_in, // sliced cable data
  input wire logic squelch_level_in, // above squelch threshold
  input wire logic collision_level_in, // below collision threshold
  input wire logic tx_neg_pulse_in, // DTE pulse below -225mV
  input wire logic disable_level_in, // beyond disable threshold
  input wire logic undervoltage_in, // supply below lockout
  input wire logic heartbeat_enable_strap_in, // low: no heartbeat
  output logic rx_enable_out, // receive squelch open
  output logic tx_enable_out, // transmit squelch open
  output logic collision_level_out, // collision pair level
  output logic collision_drive_out, // collision pair active
  output logic aui_driver_oe_out, // AUI drivers enabled
  output logic driver_power_out, // AUI drivers powered
  output logic jabber_out, // jabber inhibit active
  output logic rx_data_out // receive data, link clock
);

  typedef struct packed {
    ctc_pkg::ctc_mode_t mode;
    ctc_pkg::ctc_colgen_t cg;
    logic [ctc_pkg::N_PIN-1:0] s1;
    logic [ctc_pkg::N_PIN-1:0] s2;
    ctc_pkg::ctc_long_t mode_t;
    ctc_pkg::ctc_long_t ann_t;
    logic rx_en;
    logic rx_seen0;
    logic rx_miss;
    logic rx_dead;
    ctc_pkg::ctc_short_t rx_t;
    logic tx_act;
    logic tx_en;
    ctc_pkg::ctc_short_t on_t;
    ctc_pkg::ctc_short_t off_t;
    logic hb_wait;
    logic hb_burst;
    ctc_pkg::ctc_short_t hb_t;
    logic jab;
    logic unjab;
    ctc_pkg::ctc_short_t unjab_t;
    ctc_pkg::ctc_long_t jab_t;
    logic col_osc;
    ctc_pkg::ctc_short_t col_t;
    logic pwr;
  } ctc_state_t;

  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
    logic rx_data;
  } ctc_link_t;

  localparam ctc_state_t RST = '{
    mode: ctc_pkg::ST_POR,
    cg: ctc_pkg::CG_IDLE,
    col_osc: 1'b1,
    default: '0
  };

  ctc_state_t q;
  ctc_state_t d;
  ctc_link_t lq;
  ctc_link_t ld;

  logic rxd;
  logic sq;
  logic col_lvl;
  logic txn;
  logic dis;
  logic uv;
  logic heartbeat_enable_strap;
  logic quiet;
  logic col_req;

  assign rxd = q.s2[ctc_pkg::P_RXD];
  assign sq = q.s2[ctc_pkg::P_SQ];
  assign col_lvl = q.s2[ctc_pkg::P_COL];
  assign txn = q.s2[ctc_pkg::P_TXN];
  assign dis = q.s2[ctc_pkg::P_DIS];
  assign uv = q.s2[ctc_pkg::P_UV];
  assign heartbeat_enable_strap = q.s2[ctc_pkg::P_HB];

  // outside normal running both squelches stay shut
  assign quiet = (q.mode != ctc_pkg::ST_RUN) | uv; // [R11] [R12] [R13]

  // no collision while waiting after power-up or under lockout
  assign col_req = !quiet & (col_lvl | q.jab | (q.hb_burst & heartbeat_enable_strap) |
                   (q.ann_t != '0)); // [R5] [R8] [R10] [R12] [R14]

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    d = q;
    d.s1 = {heartbeat_enable_strap_in, undervoltage_in, disable_level_in,
            tx_neg_pulse_in, collision_level_in, squelch_level_in,
            coax_receive_input_in};
    d.s2 = q.s1;

    // power-up wait, disconnect watch and reconnect
    case (q.mode)
      ctc_pkg::ST_POR: begin
        if (uv) begin
          d.mode_t = '0;
        end else if (q.mode_t == ctc_pkg::ctc_long_t'(POR_CYC - 1)) begin
          d.mode = ctc_pkg::ST_RUN; // [R12] [R20]
          d.mode_t = '0;
        end else begin
          d.mode_t = q.mode_t + 25'h0000001; // [R19]
        end
      end
      ctc_pkg::ST_RUN: begin
        if (!dis) begin
          d.mode_t = '0;
        end else if (q.mode_t == ctc_pkg::ctc_long_t'(DISC_CYC - 1)) begin
          d.mode = ctc_pkg::ST_DISC; // [R13]
          d.mode_t = '0;
        end else begin
          d.mode_t = q.mode_t + 25'h0000001;
        end
        // announcement starts on the first cycle of a disconnect
        if (dis && q.mode_t == '0 && q.ann_t == '0) begin
          d.ann_t = ctc_pkg::ctc_long_t'(ANN_CYC); // [R14]
        end
      end
      ctc_pkg::ST_DISC: begin
        if (!dis) begin
          d.mode = ctc_pkg::ST_RUN; // [R15]
        end
      end
      default: begin
        d.mode = ctc_pkg::ST_POR;
        d.mode_t = '0;
      end
    endcase
    if (q.ann_t != '0) begin
      d.ann_t = q.ann_t - 25'h0000001;
    end

    // receive squelch
    if (q.rx_dead) begin
      if (q.rx_t == ctc_pkg::ctc_short_t'(ctc_pkg::RX_BLANK_CYC - 1)) begin
        d.rx_dead = 1'b0; // [R2]
        d.rx_t = '0;
        d.rx_seen0 = 1'b0;
        d.rx_miss = 1'b0;
      end else begin
        d.rx_t = q.rx_t + 5'h01;
      end
    end else if (quiet || !sq) begin
      d.rx_en = 1'b0; // [R11] [R17]
      d.rx_seen0 = 1'b0;
      d.rx_miss = 1'b0;
      d.rx_t = '0;
    end else if (q.rx_en) begin
      if (!rxd) begin
        d.rx_t = '0;
      end else if (q.rx_t ==
                   ctc_pkg::ctc_short_t'(ctc_pkg::RX_HIGH_CYC - 1)) begin
        d.rx_en = 1'b0; // [R2]
        d.rx_dead = 1'b1;
        d.rx_t = '0;
      end else begin
        d.rx_t = q.rx_t + 5'h01;
      end
    end else if (!q.rx_miss) begin
      // window for the 0-then-1 start; a late start is ignored
      if (q.rx_seen0 && rxd) begin
        d.rx_en = 1'b1; // [R1]
        d.rx_t = '0;
      end else if (q.rx_t ==
                   ctc_pkg::ctc_short_t'(ctc_pkg::RX_OPEN_CYC - 1)) begin
        d.rx_miss = 1'b1; // [R1]
      end else begin
        d.rx_t = q.rx_t + 5'h01;
        if (!rxd) begin
          d.rx_seen0 = 1'b1;
        end
      end
    end

    // transmit squelch from DTE pulse activity
    if (txn) begin
      d.off_t = '0;
      if (q.on_t != 5'h1F) begin
        d.on_t = q.on_t + 5'h01;
      end
      if (q.on_t == ctc_pkg::ctc_short_t'(ctc_pkg::TX_ON_CYC - 1)) begin
        d.tx_act = 1'b1; // [R3]
      end
    end else begin
      d.on_t = '0;
      if (q.tx_act) begin
        if (q.off_t == ctc_pkg::ctc_short_t'(ctc_pkg::TX_OFF_CYC - 1)) begin
          d.tx_act = 1'b0; // [R4]
          d.off_t = '0;
        end else begin
          d.off_t = q.off_t + 5'h01;
        end
      end
    end

    // jabber and unjab
    if (q.tx_en) begin
      if (q.jab_t == ctc_pkg::ctc_long_t'(JAB_CYC - 1)) begin
        d.jab = 1'b1; // [R9]
        d.jab_t = '0;
      end else begin
        d.jab_t = q.jab_t + 25'h0000001;
      end
    end else begin
      d.jab_t = '0;
    end
    if (q.jab && !q.unjab && !q.tx_act) begin
      d.unjab = 1'b1; // [R10]
      d.unjab_t = '0;
    end
    if (q.unjab) begin
      if (q.unjab_t == ctc_pkg::ctc_short_t'(ctc_pkg::UNJAB_CYC - 1)) begin
        d.unjab = 1'b0; // [R10]
        d.jab = 1'b0;
      end else begin
        d.unjab_t = q.unjab_t + 5'h01;
      end
    end
    d.tx_en = d.tx_act & !quiet & !d.jab; // [R9] [R11]

    // heartbeat after a normal end of transmission
    if (q.tx_en && !d.tx_act && heartbeat_enable_strap) begin
      d.hb_wait = 1'b1; // [R7] [R8]
      d.hb_burst = 1'b0;
      d.hb_t = '0;
    end else if (q.hb_wait) begin
      if (q.hb_t == ctc_pkg::ctc_short_t'(ctc_pkg::HB_WAIT_CYC - 1)) begin
        d.hb_wait = 1'b0; // [R18]
        d.hb_burst = 1'b1;
        d.hb_t = '0;
      end else begin
        d.hb_t = q.hb_t + 5'h01;
      end
    end else if (q.hb_burst) begin
      if (q.hb_t == ctc_pkg::ctc_short_t'(ctc_pkg::HB_BURST_CYC - 1)) begin
        d.hb_burst = 1'b0; // [R7]
      end else begin
        d.hb_t = q.hb_t + 5'h01;
      end
    end

    // collision oscillator; half period is whole cycles only, so the
    // 25MHz reference gives 12.5MHz rather than exactly 10MHz
    case (q.cg)
      ctc_pkg::CG_IDLE: begin
        d.col_osc = 1'b1;
        if (col_req) begin
          d.cg = ctc_pkg::CG_OSC;
          d.col_osc = 1'b0; // [R6]
          d.col_t = '0;
        end
      end
      ctc_pkg::CG_OSC: begin
        if (!col_req) begin
          d.cg = ctc_pkg::CG_TAIL;
          d.col_osc = 1'b1; // [R6]
          d.col_t = '0;
        end else if (q.col_t ==
                     ctc_pkg::ctc_short_t'(ctc_pkg::COL_HALF_CYC - 1)) begin
          d.col_osc = ~q.col_osc; // [R5]
          d.col_t = '0;
        end else begin
          d.col_t = q.col_t + 5'h01;
        end
      end
      ctc_pkg::CG_TAIL: begin
        // tail runs out even if a new request comes, to keep the shape
        if (q.col_t == ctc_pkg::ctc_short_t'(ctc_pkg::COL_TAIL_CYC - 1)) begin
          d.cg = ctc_pkg::CG_IDLE; // [R6]
        end else begin
          d.col_t = q.col_t + 5'h01;
        end
      end
      default: begin
        d.cg = ctc_pkg::CG_IDLE;
        d.col_osc = 1'b1;
      end
    endcase

    d.pwr = (sq & !quiet) | d.rx_en | (d.cg != ctc_pkg::CG_IDLE); // [R16]
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      q <= RST; // [R20]
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // link domain: only cable data reaches the DTE receive output
  always_comb begin
    ld = lq;
    ld.s1 = {q.rx_en, coax_receive_input_in};
    ld.s2 = lq.s1;
    ld.rx_data = lq.s2[1] & lq.s2[0]; // [R17]
  end

  always_ff @(posedge link_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      lq <= '0;
    end else begin
      lq <= ld;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign rx_enable_out = q.rx_en;
  assign tx_enable_out = q.tx_en;
  assign collision_level_out = q.col_osc;
  assign collision_drive_out = (q.cg != ctc_pkg::CG_IDLE);
  assign aui_driver_oe_out = (q.mode != ctc_pkg::ST_DISC); // [R13] [R15]
  assign driver_power_out = q.pwr;
  assign jabber_out = q.jab;
  assign rx_data_out = lq.rx_data;

endmodule : ctc_coax_ctrl

//--- tb/ctc_coax_ctrl_tb.sv
// testbench for the coax transceiver control block
`timescale 1ns/1ns
module ctc_coax_ctrl_tb;
  localparam int JAB = 40;
  localparam int POR = 50;
  logic clk_in = 1'b0;
  logic link_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic rxd = 1'b0, sq = 1'b0, col = 1'b0, dis = 1'b0, uv = 1'b0;
  logic hb = 1'b1, send = 1'b0, txp;
  logic rx_en, tx_en, col_lvl, col_drv, oe, pwr, jab, rx_data;
  logic rx_hi, tx_hi, jab_hi, pwr_hi, oe_lo;
  logic [15:0] ones, ones0;
  logic [31:0] seed = 32'h54FB;
  int error_cnt = 0;
  int checks_done = 0;
  int n, first, tick, t_end;
  always #20 clk_in = ~clk_in;
  initial begin
    #7;
    forever #80 link_clk_in = ~link_clk_in;
  end
  ctc_coax_ctrl #(.JAB_CYC(JAB), .POR_CYC(POR), .DISC_CYC(100),
    .ANN_CYC(30)) ctc_coax_ctrl_i (.clk_in(clk_in),
    .sys_rst_in(sys_rst_in), .link_clk_in(link_clk_in),
    .coax_receive_input_in(rxd), .squelch_level_in(sq),
    .collision_level_in(col), .tx_neg_pulse_in(txp),
    .disable_level_in(dis), .undervoltage_in(uv),
    .heartbeat_enable_strap_in(hb), .rx_enable_out(rx_en),
    .tx_enable_out(tx_en), .collision_level_out(col_lvl),
    .collision_drive_out(col_drv), .aui_driver_oe_out(oe),
    .driver_power_out(pwr), .jabber_out(jab), .rx_data_out(rx_data));
  ctc_dte_model ctc_dte_model_i (.clk_in(clk_in),
    .link_clk_in(link_clk_in), .send_in(send), .rx_data_in(rx_data),
    .tx_neg_pulse_out(txp), .rx_ones_out(ones));
////////////////////////////////////////////////////////////////////////
  // sticky observations, taken at the settled falling edge
  always @(negedge clk_in) begin
    if (col_drv === 1'b1 && first < 0) first = tick;
    n += (col_drv === 1'b1);
    tick++;
    rx_hi |= (rx_en === 1'b1);
    tx_hi |= (tx_en === 1'b1);
    jab_hi |= (jab === 1'b1);
    pwr_hi |= (pwr === 1'b1);
    oe_lo |= (oe === 1'b0);
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic int hb_model(input logic strap);
    return strap ? ctc_pkg::HB_BURST_CYC + ctc_pkg::COL_TAIL_CYC : 0;
  endfunction : hb_model
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: saw %0h, want %0h", $time, seen, exp);
    end
  endtask : check
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_in);
  endtask : cyc
  task automatic clr;
    {n, tick, first} = {32'd0, 32'd0, -32'sd1};
    {rx_hi, tx_hi, jab_hi, pwr_hi, oe_lo} = 5'h00;
  endtask : clr
  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (5000) @(posedge clk_in);
    error_cnt++;
    wrap_up();
  end
////////////////////////////////////////////////////////////////////////
  initial begin
    clr();
    cyc(4);
    sys_rst_in <= 1'b0;
    send <= 1'b1;
    cyc(20);
    send <= 1'b0;
    check(tx_hi, 0);
    check(n, 0);
    cyc(POR);
    clr();
    sq <= 1'b1;
    // highs last one link period: a fixed-phase miss is impossible
    for (int i = 0; i < 24; i++) begin
      rxd <= i[2];
      cyc(1);
    end
    check(rx_hi, 1);
    check(pwr_hi, 1);
    rxd <= 1'b1;
    cyc(10);
    // link path is three link edges deep, so look only after it drains
    check(ones != 16'h0000, 1);
    clr();
    // a fresh start inside the blanking time must stay shut
    for (int i = 0; i < 6; i++) begin
      rxd <= i[1];
      cyc(1);
    end
    check(rx_hi, 0);
    {sq, rxd} <= 2'b00;
    cyc(20);
    ones0 = ones;
    for (int s = 0; s < 2; s++) begin
      hb <= s[0];
      cyc(4);
      clr();
      seed = lfsr(seed);
      send <= 1'b1;
      cyc(8 + int'(seed[3:0]));
      send <= 1'b0;
      t_end = tick;
      cyc(90);
      check(tx_hi, 1);
      check(n, hb_model(s[0]));
      if (s == 0) check(pwr_hi, 0);
      if (s == 1) check(first - t_end inside {[22:47]}, 1);
    end
    check(ones, ones0);
    clr();
    col <= 1'b1;
    cyc(20);
    col <= 1'b0;
    cyc(20);
    check(first >= 0 && first <= 17, 1);
    clr();
    send <= 1'b1;
    cyc(JAB + 20);
    send <= 1'b0;
    check(jab_hi, 1);
    check(n > 0, 1);
    cyc(30);
    clr();
    cyc(60);
    check(jab_hi, 0);
    send <= 1'b1;
    cyc(10);
    send <= 1'b0;
    cyc(40);
    check(tx_hi, 1);
    uv <= 1'b1;
    cyc(6);
    clr();
    send <= 1'b1;
    cyc(10);
    send <= 1'b0;
    cyc(4);
    check(tx_hi, 0);
    uv <= 1'b0;
    cyc(POR + 10);
    clr();
    dis <= 1'b1;
    cyc(110);
    // announcement length set at the instance, plus the high tail
    check(n, 30 + ctc_pkg::COL_TAIL_CYC);
    clr();
    send <= 1'b1;
    cyc(15);
    send <= 1'b0;
    check(oe_lo && !tx_hi, 1);
    // let the packet die while cut off, or reconnect resumes it
    cyc(10);
    dis <= 1'b0;
    cyc(10);
    clr();
    cyc(60);
    check({oe_lo, n}, 0);
    wrap_up();
  end
endmodule : ctc_coax_ctrl_tb

//--- tb/ctc_dte_model.sv
// dte model: sends pulse packets, counts received ones
`timescale 1ns/1ns
module ctc_dte_model (
  input wire logic clk_in, // ref clock
  input wire logic link_clk_in, // link clock
  input wire logic send_in, // packet in progress
  input wire logic rx_data_in, // from the block
  output logic tx_neg_pulse_out, // pulse to the block
  output logic [15:0] rx_ones_out // received ones
);
  logic phase_q = 1'b0;
  initial tx_neg_pulse_out = 1'b0;
  initial rx_ones_out = 16'h0000;
  // pulse first, one-cycle gaps keep well inside the off time
  always @(posedge clk_in) begin
    phase_q <= send_in ? ~phase_q : 1'b0;
    tx_neg_pulse_out <= send_in & ~phase_q;
  end
  always @(posedge link_clk_in) begin
    rx_ones_out <= rx_ones_out + {15'h0000, rx_data_in};
  end
endmodule : ctc_dte_model

//--- tb/ctc_props.sv
// assertion checker for the coax transceiver control block
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////
module ctc_props #(
  parameter int JAB_CYC = 40,
  parameter int POR_CYC = 50,
  parameter int DISC_CYC = 100
) (
  input wire logic clk_in, // ref clock
  input wire logic sys_rst_in, // reset
  input wire logic tx_neg_pulse_in, // dte pulse
  input wire logic collision_level_in, // cable level
  input wire logic disable_level_in, // cable open
  input wire logic heartbeat_enable_strap_in, // strap
  input wire logic rx_enable_out, // rx open
  input wire logic tx_enable_out, // tx open
  input wire logic collision_level_out, // pair level
  input wire logic collision_drive_out, // pair active
  input wire logic aui_driver_oe_out, // drivers on
  input wire logic jabber_out // jabber
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  int por_q, quiet_q, dis_q, tx_q;
  logic quiet;
  assign quiet = !(heartbeat_enable_strap_in || collision_level_in ||
    disable_level_in || jabber_out);
  // counters other than tx_q saturate far beyond any bound used below
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      por_q <= 0;
      quiet_q <= 0;
      dis_q <= 0;
      tx_q <= 0;
    end else begin
      por_q <= (por_q < 100000) ? por_q + 1 : por_q;
      quiet_q <= quiet ? ((quiet_q < 1000) ? quiet_q + 1 : quiet_q) : 0;
      dis_q <= disable_level_in ? ((dis_q < 1000) ? dis_q + 1 : dis_q) : 0;
      tx_q <= tx_enable_out ? tx_q + 1 : 0;
    end
  end
////////////////////////////////////////////////////////////////////////
  por_idle_a: assert property (
    por_q < POR_CYC |-> !tx_enable_out && !rx_enable_out
      && !collision_drive_out) else $error("active in power-up wait");
  tx_open_a: assert property (
    $rose(tx_enable_out) |-> $past(tx_neg_pulse_in, 2) ||
      $past(tx_neg_pulse_in, 3) || $past(tx_neg_pulse_in, 4))
    else $error("transmit opened without a pulse");
  tx_close_a: assert property (
    (!tx_neg_pulse_in)[*8] |-> ##2 !tx_enable_out)
    else $error("transmit stayed open");
  osc_half_a: assert property (
    collision_drive_out && !collision_level_out |=> collision_level_out)
    else $error("low half too long");
  start_low_a: assert property (
    $rose(collision_drive_out) |-> !collision_level_out)
    else $error("collision did not start low");
  tail_high_a: assert property (
    $fell(collision_drive_out) |-> $past(collision_level_out, 1) &&
      $past(collision_level_out, 3) && $past(collision_level_out, 5))
    else $error("collision tail too short");
  hb_quiet_a: assert property (
    quiet_q > 70 |-> !collision_drive_out)
    else $error("collision with heartbeat strapped off");
  jab_limit_a: assert property (
    tx_q <= JAB_CYC + 6) else $error("transmit beyond jabber time");
  disc_hiz_a: assert property (
    dis_q > DISC_CYC + 4 |-> !aui_driver_oe_out && !rx_enable_out &&
      !tx_enable_out) else $error("drivers on while disconnected");
  cover property ($rose(collision_drive_out) && quiet);
  cover property ($rose(jabber_out));
  cover property ($fell(aui_driver_oe_out));
endmodule : ctc_props

bind ctc_coax_ctrl ctc_props #(.JAB_CYC(JAB_CYC), .POR_CYC(POR_CYC),
  .DISC_CYC(DISC_CYC)) ctc_props_i (.clk_in(clk_in),
  .sys_rst_in(sys_rst_in), .tx_neg_pulse_in(tx_neg_pulse_in),
  .collision_level_in(collision_level_in),
  .disable_level_in(disable_level_in),
  .heartbeat_enable_strap_in(heartbeat_enable_strap_in),
  .rx_enable_out(rx_enable_out), .tx_enable_out(tx_enable_out),
  .collision_level_out(collision_level_out),
  .collision_drive_out(collision_drive_out),
  .aui_driver_oe_out(aui_driver_oe_out), .jabber_out(jabber_out));
